// ---- design/instr_fetch_operand_decode.sv ----
// The address map and the AXI4-Lite register port are this design's own decisions.
module instr_fetch_operand_decode (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Instruction stream
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word_in,
    input wire logic skip_in,
    input wire logic branch_taken_in,
    input wire logic [7:0] acc_in,
    output logic [decode_pkg::PC_W-1:0] fetch_addr_out,
    // Decode results
    output logic exec_valid_out,
    output logic nop_out,
    output logic [2:0] mode_out,
    output logic [1:0] dest_out,
    output logic [decode_pkg::DADDR_W-1:0] data_addr_out,
    output logic [decode_pkg::DADDR_W-1:0] literal_out,
    output logic call_out,
    // AXI4-Lite slave
    input wire logic [decode_pkg::AXI_AW-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [decode_pkg::AXI_AW-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in
);
    import decode_pkg::*;

    ptr_if pif ();

    ptr_unit u_ptr (
        .clk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .p(pif.unit)
    );

    // Decode state
    logic [PC_W-1:0] pc_reg, pc_next;
    seq_state_e seq_reg, seq_next;
    two_kind_e kind_reg, kind_next;
    logic [15:0] first_reg, first_next;
    logic exec_reg, exec_next;
    logic nop_reg, nop_next;
    addr_mode_e mode_reg, mode_next;
    dest_e dest_reg, dest_next;
    logic [DADDR_W-1:0] daddr_reg, daddr_next;
    logic [DADDR_W-1:0] lit_reg, lit_next;
    logic call_reg, call_next;

    // Register file state
    logic extended_set_enable_reg, extended_set_enable_next;
    logic [BANK_W-1:0] bank_reg, bank_next;

    logic [PC_W-1:0] pc_plus2;
    logic [15:0] w;
    logic direct_op;
    logic has_d;

    assign w = instr_word_in;
    assign pc_plus2 = pc_reg + PC_STEP;
    assign has_d = (w[15:12] >= OP_BYTE_LO) && (w[15:12] <= OP_BYTE_HI);
    assign direct_op = has_d || (w[15:12] == OP_NOD) || ((w[15:12] >= OP_BIT_LO) && (w[15:12] <= OP_BIT_HI));

    // Operand resolver drive
    always_comb begin
        pif.exec = instr_valid_in && !skip_in && direct_op;
        pif.addr8 = w[7:0];
        pif.access_sel = w[BIT_A];
        pif.bank = bank_reg;
        pif.extended_set_enable = extended_set_enable_reg;
        pif.offset = acc_in;
        pif.load_en = instr_valid_in && !skip_in && seq_reg == SEQ_SECOND && kind_reg == KIND_PLOAD
            && w[15:12] == OP_SECOND;
        pif.load_idx = first_reg[5:4];
        pif.load_val = {first_reg[3:0], w[7:0]};
    end

    always_comb begin
        pc_next = pc_reg;
        seq_next = seq_reg;
        kind_next = kind_reg;
        first_next = first_reg;
        exec_next = 1'b0;
        nop_next = 1'b0;
        mode_next = mode_reg;
        dest_next = dest_reg;
        daddr_next = daddr_reg;
        lit_next = lit_reg;
        call_next = 1'b0;
        if (instr_valid_in) begin
            pc_next = pc_plus2;
            if (skip_in) begin
                seq_next = SEQ_FIRST;
                kind_next = KIND_NONE;
            end else if (seq_reg == SEQ_SECOND && w[15:12] == OP_SECOND) begin
                exec_next = 1'b1;
                seq_next = SEQ_FIRST;
                kind_next = KIND_NONE;
                lit_next = w[11:0];
                dest_next = DEST_NONE;
                mode_next = MODE_LITERAL;
                case (kind_reg)
                    KIND_JUMP, KIND_CALL: begin
                        pc_next = {w[11:0], first_reg[7:0], 1'b0};
                        call_next = kind_reg == KIND_CALL;
                    end
                    KIND_FMOVE: begin
                        mode_next = MODE_ABSOLUTE;
                        daddr_next = w[11:0];
                        dest_next = DEST_FILE;
                    end
                    default: mode_next = MODE_LITERAL;
                endcase
            end else begin
                exec_next = 1'b1;
                seq_next = SEQ_FIRST;
                kind_next = KIND_NONE;
                first_next = w;
                dest_next = DEST_NONE;
                lit_next = {4'h0, w[7:0]};
                if (w[15:12] == OP_SECOND) begin
                    nop_next = 1'b1;
                    mode_next = MODE_INHERENT;
                end else if (w[15:8] == OP_INHERENT) begin
                    mode_next = MODE_INHERENT;
                end else if (w[15:8] == OP_LIT_MOVE || w[15:8] == OP_LIT_ADD) begin
                    mode_next = MODE_LITERAL;
                    dest_next = DEST_ACC;
                end else if (w[15:12] == OP_FMOVE) begin
                    mode_next = MODE_ABSOLUTE;
                    daddr_next = w[11:0];
                    lit_next = w[11:0];
                    seq_next = SEQ_SECOND;
                    kind_next = KIND_FMOVE;
                end else if (w[15:8] == OP_JUMP) begin
                    mode_next = MODE_LITERAL;
                    seq_next = SEQ_SECOND;
                    kind_next = KIND_JUMP;
                end else if (w[15:9] == OP_CALL) begin
                    mode_next = MODE_LITERAL;
                    seq_next = SEQ_SECOND;
                    kind_next = KIND_CALL;
                end else if (w[15:8] == OP_PLOAD) begin
                    mode_next = MODE_LITERAL;
                    seq_next = SEQ_SECOND;
                    kind_next = KIND_PLOAD;
                end else if (w[15:11] == OP_BRA) begin
                    mode_next = MODE_LITERAL;
                    lit_next = {1'b0, w[10:0]};
                    pc_next = pc_plus2 + {{9{w[10]}}, w[10:0], 1'b0};
                end else if (w[15:11] == OP_BCOND) begin
                    mode_next = MODE_LITERAL;
                    if (branch_taken_in) begin
                        pc_next = pc_plus2 + {{12{w[7]}}, w[7:0], 1'b0};
                    end
                end else if (direct_op) begin
                    daddr_next = pif.eff_addr;
                    if (pif.indirect) begin
                        mode_next = MODE_INDIRECT;
                    end else if (pif.indexed) begin
                        mode_next = MODE_INDEXED;
                    end else begin
                        mode_next = MODE_DIRECT;
                    end
                    if (has_d) begin
                        dest_next = w[BIT_D] ? DEST_FILE : DEST_ACC;
                    end else begin
                        dest_next = DEST_FILE;
                    end
                end else begin
                    mode_next = MODE_LITERAL;
                    dest_next = DEST_ACC;
                end
            end
            pc_next[0] = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            pc_reg <= PC_RESET;
            seq_reg <= SEQ_FIRST;
            kind_reg <= KIND_NONE;
            first_reg <= 16'h0000;
            exec_reg <= 1'b0;
            nop_reg <= 1'b0;
            mode_reg <= MODE_NONE;
            dest_reg <= DEST_NONE;
            daddr_reg <= 12'h000;
            lit_reg <= 12'h000;
            call_reg <= 1'b0;
        end else begin
            pc_reg <= pc_next;
            seq_reg <= seq_next;
            kind_reg <= kind_next;
            first_reg <= first_next;
            exec_reg <= exec_next;
            nop_reg <= nop_next;
            mode_reg <= mode_next;
            dest_reg <= dest_next;
            daddr_reg <= daddr_next;
            lit_reg <= lit_next;
            call_reg <= call_next;
        end
    end

    assign fetch_addr_out = pc_reg;
    assign exec_valid_out = exec_reg;
    assign nop_out = nop_reg;
    assign mode_out = mode_reg;
    assign dest_out = dest_reg;
    assign data_addr_out = daddr_reg;
    assign literal_out = lit_reg;
    assign call_out = call_reg;

    // AXI4-Lite slave
    logic aw_held_reg, aw_held_next;
    logic w_held_reg, w_held_next;
    logic [AXI_AW-1:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic do_write;
    logic [AXI_AW-1:0] ptr_off;
    logic [31:0] rd_val;
    logic rd_ok;

    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign ptr_off = awaddr_reg - REG_PTR0;

    always_comb begin
        pif.bus_wr_en = 1'b0;
        pif.bus_wr_idx = ptr_off[3:2];
        pif.bus_wr_val = wdata_reg[DADDR_W-1:0];
        if (do_write && awaddr_reg >= REG_PTR0 && ptr_off < AXI_AW'(NUM_PTR * REG_PTR_STEP)
            && ptr_off[1:0] == 2'h0 && wstrb_reg[0]) begin
            pif.bus_wr_en = 1'b1;
        end
    end

    always_comb begin
        logic [AXI_AW-1:0] roff;
        roff = s_axi_araddr_in - REG_PTR0;
        rd_ok = 1'b1;
        rd_val = 32'h00000000;
        case (s_axi_araddr_in)
            REG_CTRL: rd_val[CTRL_EXTENDED_SET_ENABLE_BIT] = extended_set_enable_reg;
            REG_BANK: rd_val[BANK_W-1:0] = bank_reg;
            REG_PC: rd_val[PC_W-1:0] = pc_reg;
            REG_STAT: rd_val[3:0] = {kind_reg, seq_reg};
            default: begin
                if (s_axi_araddr_in >= REG_PTR0 && roff < AXI_AW'(NUM_PTR * REG_PTR_STEP) && roff[1:0] == 2'h0) begin
                    rd_val[DADDR_W-1:0] = pif.fsr_val[roff[3:2]];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
    end

    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        extended_set_enable_next = extended_set_enable_reg;
        bank_next = bank_reg;
        if (s_axi_awvalid_in && !aw_held_reg) begin
            aw_held_next = 1'b1;
            awaddr_next = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !w_held_reg) begin
            w_held_next = 1'b1;
            wdata_next = s_axi_wdata_in;
            wstrb_next = s_axi_wstrb_in;
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            if (awaddr_reg == REG_CTRL) begin
                if (wstrb_reg[0]) begin
                    extended_set_enable_next = wdata_reg[CTRL_EXTENDED_SET_ENABLE_BIT];
                end
            end else if (awaddr_reg == REG_BANK) begin
                if (wstrb_reg[0]) begin
                    bank_next = wdata_reg[BANK_W-1:0];
                end
            end else if (!pif.bus_wr_en && !(awaddr_reg >= REG_PTR0 && ptr_off < AXI_AW'(NUM_PTR * REG_PTR_STEP)
                && ptr_off[1:0] == 2'h0)) begin
                bresp_next = RESP_DECERR;
            end
        end else if (bvalid_reg && s_axi_bready_in) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid_in && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rdata_next = rd_val;
            rresp_next = rd_ok ? RESP_OKAY : RESP_DECERR;
        end else if (rvalid_reg && s_axi_rready_in) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= 32'h00000000;
            extended_set_enable_reg <= 1'b0;
            bank_reg <= 4'h0;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            extended_set_enable_reg <= extended_set_enable_next;
            bank_reg <= bank_next;
        end
    end

    assign s_axi_awready_out = !aw_held_reg;
    assign s_axi_wready_out = !w_held_reg;
    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out = bresp_reg;
    assign s_axi_arready_out = !rvalid_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rresp_out = rresp_reg;
    assign s_axi_rdata_out = rdata_reg;
endmodule : instr_fetch_operand_decode

// ---- design/decode_pkg.sv ----
package decode_pkg;
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int NUM_PTR = 3;
    localparam int AXI_AW = 8;
    localparam int IDX_PTR = 2;

    localparam logic [20:0] PC_RESET = 21'h000000;
    localparam logic [20:0] PC_STEP = 21'h000002;

    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BANK = 8'h04;
    localparam logic [7:0] REG_PC = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_PTR0 = 8'h10;
    localparam logic [7:0] REG_PTR_STEP = 8'h04;
    localparam int CTRL_EXTENDED_SET_ENABLE_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Opcode fields
    localparam logic [7:0] OP_INHERENT = 8'h00;
    localparam logic [7:0] OP_LIT_MOVE = 8'h0E;
    localparam logic [7:0] OP_LIT_ADD = 8'h0F;
    localparam logic [3:0] OP_FMOVE = 4'hC;
    localparam logic [3:0] OP_SECOND = 4'hF;
    localparam logic [7:0] OP_JUMP = 8'hEF;
    localparam logic [6:0] OP_CALL = 7'h76;
    localparam logic [7:0] OP_PLOAD = 8'hEE;
    localparam logic [4:0] OP_BRA = 5'h1A;
    localparam logic [4:0] OP_BCOND = 5'h1C;
    localparam logic [3:0] OP_BYTE_LO = 4'h1;
    localparam logic [3:0] OP_BYTE_HI = 4'h5;
    localparam logic [3:0] OP_NOD = 4'h6;
    localparam logic [3:0] OP_BIT_LO = 4'h7;
    localparam logic [3:0] OP_BIT_HI = 4'hB;
    localparam int BIT_D = 9;
    localparam int BIT_A = 8;

    // Data space layout
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [7:0] IDX_LIMIT = 8'h60;
    localparam logic [7:0] IND_BASE = 8'hE0;
    localparam logic [7:0] IND_STRIDE = 8'h08;
    localparam logic [2:0] IND_PLAIN = 3'h0;
    localparam logic [2:0] IND_POSTINC = 3'h1;
    localparam logic [2:0] IND_POSTDEC = 3'h2;
    localparam logic [2:0] IND_PREINC = 3'h3;
    localparam logic [2:0] IND_PLUSW = 3'h4;

    typedef enum logic [2:0] {
        MODE_NONE = 3'b000,
        MODE_INHERENT = 3'b001,
        MODE_LITERAL = 3'b010,
        MODE_DIRECT = 3'b011,
        MODE_INDIRECT = 3'b100,
        MODE_INDEXED = 3'b101,
        MODE_ABSOLUTE = 3'b110
    } addr_mode_e;

    typedef enum logic [1:0] {
        DEST_NONE = 2'b00,
        DEST_ACC = 2'b01,
        DEST_FILE = 2'b10
    } dest_e;

    typedef enum logic [2:0] {
        KIND_NONE = 3'b000,
        KIND_JUMP = 3'b001,
        KIND_CALL = 3'b010,
        KIND_FMOVE = 3'b011,
        KIND_PLOAD = 3'b100
    } two_kind_e;

    typedef enum logic [0:0] {
        SEQ_FIRST = 1'b0,
        SEQ_SECOND = 1'b1
    } seq_state_e;
endpackage : decode_pkg

// ---- design/ptr_if.sv ----
interface ptr_if;
    import decode_pkg::*;
    logic exec;
    logic [7:0] addr8;
    logic access_sel;
    logic [BANK_W-1:0] bank;
    logic extended_set_enable;
    logic [7:0] offset;
    logic load_en;
    logic [1:0] load_idx;
    logic [DADDR_W-1:0] load_val;
    logic bus_wr_en;
    logic [1:0] bus_wr_idx;
    logic [DADDR_W-1:0] bus_wr_val;
    logic [DADDR_W-1:0] eff_addr;
    logic indirect;
    logic indexed;
    logic [DADDR_W-1:0] fsr_val [NUM_PTR];

    modport core (output exec, addr8, access_sel, bank, extended_set_enable, offset, load_en, load_idx, load_val,
        bus_wr_en, bus_wr_idx, bus_wr_val, input eff_addr, indirect, indexed, fsr_val);
    modport unit (input exec, addr8, access_sel, bank, extended_set_enable, offset, load_en, load_idx, load_val,
        bus_wr_en, bus_wr_idx, bus_wr_val, output eff_addr, indirect, indexed, fsr_val);
endinterface : ptr_if

// ---- design/ptr_unit.sv ----
module ptr_unit (
    input wire logic clk_in,
    input wire logic rst_b_in,
    ptr_if.unit p
);
    import decode_pkg::*;

    logic [DADDR_W-1:0] fsr_reg [NUM_PTR];
    logic [DADDR_W-1:0] fsr_next [NUM_PTR];

    genvar g;
    for (g = 0; g < NUM_PTR; g++) begin : g_ptr
        localparam logic [7:0] BASE = 8'(IND_BASE + g * IND_STRIDE);
        logic hit;
        assign hit = p.exec && !p.access_sel && (p.addr8[7:3] == BASE[7:3]) && (p.addr8[2:0] <= IND_PLUSW);
        always_comb begin
            fsr_next[g] = fsr_reg[g];
            if (p.bus_wr_en && p.bus_wr_idx == 2'(g)) begin
                fsr_next[g] = p.bus_wr_val;
            end else if (p.load_en && p.load_idx == 2'(g)) begin
                fsr_next[g] = p.load_val;
            end else if (hit) begin
                case (p.addr8[2:0])
                    IND_POSTINC, IND_PREINC: fsr_next[g] = fsr_reg[g] + 12'h001;
                    IND_POSTDEC: fsr_next[g] = fsr_reg[g] - 12'h001;
                    default: fsr_next[g] = fsr_reg[g];
                endcase
            end
        end
        always_ff @(posedge clk_in) begin
            if (!rst_b_in) begin
                fsr_reg[g] <= 12'h000;
            end else begin
                fsr_reg[g] <= fsr_next[g];
            end
        end
        assign p.fsr_val[g] = fsr_reg[g];
    end

    // Effective data address for the current operand
    always_comb begin
        logic [7:0] base;
        base = IND_BASE;
        p.indirect = 1'b0;
        p.indexed = 1'b0;
        if (p.access_sel) begin
            p.eff_addr = {p.bank, p.addr8};
        end else if (p.addr8 >= ACCESS_SPLIT) begin
            p.eff_addr = {ACCESS_HI_BANK, p.addr8};
        end else begin
            p.eff_addr = {ACCESS_LO_BANK, p.addr8};
        end
        if (!p.access_sel && p.extended_set_enable && p.addr8 < IDX_LIMIT) begin
            p.eff_addr = fsr_reg[IDX_PTR] + {4'h0, p.addr8};
            p.indexed = 1'b1;
        end
        for (int i = 0; i < NUM_PTR; i++) begin
            base = 8'(IND_BASE + i * IND_STRIDE);
            if (!p.access_sel && p.addr8[7:3] == base[7:3] && p.addr8[2:0] <= IND_PLUSW) begin
                p.indirect = 1'b1;
                case (p.addr8[2:0])
                    IND_PREINC: p.eff_addr = fsr_reg[i] + 12'h001;
                    IND_PLUSW: p.eff_addr = fsr_reg[i] + {{4{p.offset[7]}}, p.offset};
                    default: p.eff_addr = fsr_reg[i];
                endcase
            end
        end
    end
endmodule : ptr_unit

// ---- tb/decode_sva.sv ----
module decode_sva (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Watched ports
    input wire logic instr_valid_in,
    input wire logic [15:0] instr_word_in,
    input wire logic skip_in,
    input wire logic [decode_pkg::PC_W-1:0] fetch_addr_out,
    input wire logic exec_valid_out,
    input wire logic nop_out,
    input wire logic [2:0] mode_out,
    input wire logic [1:0] dest_out,
    input wire logic [decode_pkg::DADDR_W-1:0] data_addr_out,
    input wire logic [decode_pkg::DADDR_W-1:0] literal_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import decode_pkg::*;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    logic pend_reg, pend_next, take, first_word;
    logic [15:0] first_reg, first_next;
    logic [3:0] top;
    assign take = instr_valid_in && !skip_in;
    assign top = instr_word_in[15:12];
    assign first_word = top == OP_FMOVE || instr_word_in[15:8] == OP_JUMP || instr_word_in[15:9] == OP_CALL
        || instr_word_in[15:8] == OP_PLOAD;
    // Pending second word tracker
    always_comb begin
        pend_next = instr_valid_in ? (take && first_word) : pend_reg;
        first_next = take ? instr_word_in : first_reg;
    end
    always_ff @(posedge mclk_in) begin
        pend_reg <= rst_b_in ? pend_next : 1'b0;
        first_reg <= rst_b_in ? first_next : 16'h0000;
    end
    property p_pc_lsb;
        fetch_addr_out[0] == 1'b0;
    endproperty
    a_pc_lsb: assert property (p_pc_lsb) else $error("counter bit zero set");
    property p_pc_step;
        take && top < 4'hD |=> fetch_addr_out == $past(fetch_addr_out) + PC_STEP;
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("counter step wrong");
    property p_orphan;
        take && top == OP_SECOND && !pend_reg |=> exec_valid_out && nop_out;
    endproperty
    a_orphan: assert property (p_orphan) else $error("orphan word not a no-operation");
    property p_jump;
        take && top == OP_SECOND && pend_reg && first_reg[15:8] == OP_JUMP
        |=> fetch_addr_out == {$past(instr_word_in[11:0]), $past(first_reg[7:0]), 1'b0} && !nop_out;
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");
    property p_move;
        take && top == OP_SECOND && pend_reg && first_reg[15:12] == OP_FMOVE
        |=> data_addr_out == $past(instr_word_in[11:0]) && dest_out == DEST_FILE;
    endproperty
    a_move: assert property (p_move) else $error("second word literal unused");
    property p_access;
        take && top inside {[4'h1:4'h5]} && !instr_word_in[8] && instr_word_in[7:5] == 3'b100
        |=> mode_out == MODE_DIRECT && data_addr_out == {ACCESS_HI_BANK, $past(instr_word_in[7:0])};
    endproperty
    a_access: assert property (p_access) else $error("access bank address wrong");
    property p_dest;
        take && top inside {[4'h1:4'h5]} |=> dest_out == ($past(instr_word_in[9]) ? DEST_FILE : DEST_ACC);
    endproperty
    a_dest: assert property (p_dest) else $error("destination wrong");
    property p_literal;
        take && (instr_word_in[15:8] == OP_LIT_MOVE || instr_word_in[15:8] == OP_LIT_ADD)
        |=> mode_out == MODE_LITERAL && literal_out == {4'h0, $past(instr_word_in[7:0])};
    endproperty
    a_literal: assert property (p_literal) else $error("literal wrong");
    property p_bra;
        take && instr_word_in[15:11] == OP_BRA |=> fetch_addr_out == $past(fetch_addr_out) + PC_STEP
            + {{9{$past(instr_word_in[10])}}, $past(instr_word_in[10:0]), 1'b0};
    endproperty
    a_bra: assert property (p_bra) else $error("branch target wrong");
endmodule : decode_sva

bind instr_fetch_operand_decode decode_sva chk (.*);

// ---- tb/prog_mem.sv ----
module prog_mem (
    // Fetch address
    input wire logic [decode_pkg::PC_W-1:0] addr_in,
    // Fetched word
    output logic [15:0] word_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import decode_pkg::*;
    logic [7:0] mem [0:21] = '{8'h55, 8'h0F, 8'h23, 8'hC1, 8'h56, 8'hF4, 8'h00, 8'hF0, 8'h0A, 8'hEF, 8'h00,
        8'hF0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hD7};
    // Byte store, low byte at the even address
    always_comb begin
        word_out = 16'h0000;
        if (addr_in < 21'h16) begin
            word_out = {mem[{addr_in[4:1], 1'b1}], mem[{addr_in[4:1], 1'b0}]};
        end
    end
endmodule : prog_mem

// ---- tb/tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import decode_pkg::*;
    logic mclk_in = 1'b0, rst_b_in = 1'b0, instr_valid_in = 1'b0, use_mem = 1'b1, skip_in = 1'b0;
    logic branch_taken_in = 1'b0, exec_valid_out, nop_out, call_out;
    logic [15:0] tb_word = 16'h0000, mem_word, instr_word_in;
    logic [7:0] acc_in = 8'h00, s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [PC_W-1:0] fetch_addr_out;
    logic [2:0] mode_out;
    logic [1:0] dest_out, s_axi_bresp_out, s_axi_rresp_out;
    logic [DADDR_W-1:0] data_addr_out, literal_out;
    logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in = 4'hF;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
    int fails = 0;
    int comparisons = 0;
    always #25 mclk_in = ~mclk_in;
    assign instr_word_in = use_mem ? mem_word : tb_word;
    prog_mem pmem (.addr_in(fetch_addr_out), .word_out(mem_word));
    instr_fetch_operand_decode uut (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_awvalid_in && s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wvalid_in && s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1);
        s_axi_bready_in <= 1'b0;
        chk(s_axi_bresp_out, RESP_OKAY);
        @(posedge mclk_in);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do begin
            @(posedge mclk_in);
            if (s_axi_arvalid_in && s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1);
        s_axi_rready_in <= 1'b0;
        chk(s_axi_rdata_out, d);
        chk(s_axi_rresp_out, r);
        @(posedge mclk_in);
    endtask : axi_rd
    task automatic issue(input logic [15:0] w);
        tb_word <= w;
        instr_valid_in <= 1'b1;
        @(posedge mclk_in);
        instr_valid_in <= 1'b0;
        @(posedge mclk_in);
    endtask : issue
    // Program image
    task automatic t_program;
        use_mem <= 1'b1;
        instr_valid_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        chk(fetch_addr_out, 32'h2);
        chk(literal_out, 32'h55);
        @(posedge mclk_in);
        chk(data_addr_out, 32'h123);
        @(posedge mclk_in);
        chk({nop_out, dest_out, data_addr_out}, {1'b0, DEST_FILE, 12'h456});
        @(posedge mclk_in);
        chk({exec_valid_out, nop_out}, 2'b11);
        repeat (2) @(posedge mclk_in);
        chk(fetch_addr_out, 32'h14);
        @(posedge mclk_in);
        chk(fetch_addr_out, 32'h14);
        instr_valid_in <= 1'b0;
        @(posedge mclk_in);
    endtask : t_program
    // Bench driven words
    task automatic t_operands;
        use_mem <= 1'b0;
        axi_wr(REG_BANK, 32'h5);
        issue(16'h2312);
        chk({mode_out, dest_out, data_addr_out}, {MODE_DIRECT, DEST_FILE, 12'h512});
        issue(16'h2080);
        chk({dest_out, data_addr_out}, {DEST_ACC, 12'hF80});
        issue(16'hEE11);
        issue(16'hF034);
        axi_rd(REG_PTR0 + REG_PTR_STEP, 32'h134, RESP_OKAY);
        issue(16'h50E9);
        chk({mode_out, data_addr_out}, {MODE_INDIRECT, 12'h134});
        axi_rd(REG_PTR0 + REG_PTR_STEP, 32'h135, RESP_OKAY);
        axi_wr(REG_CTRL, 32'h1);
        issue(16'h5010);
        chk({mode_out, data_addr_out}, {MODE_INDEXED, 12'h010});
        issue(16'hEC05);
        issue(16'hF001);
        chk({call_out, fetch_addr_out}, 32'h20020A);
        axi_rd(8'h40, 32'h0, RESP_DECERR);
    endtask : t_operands
    initial begin
        repeat (2) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        t_program();
        t_operands();
        wrap_up();
    end
    // Watchdog
    initial begin
        repeat (2000) @(posedge mclk_in);
        fails++;
        wrap_up();
    end
endmodule : tb_top
